// [tmr_dual_timer.sv]
// dual 8-bit timer with event counter and square wave output
`timescale 1ns/1ns
module tmr_dual_timer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // register bus
  input  wire logic [15:0] bus_addr_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_bit_i,
  input  wire logic [2:0]  bus_bit_pos_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_rd_i,
  output logic      [7:0]  bus_rdata_o,
  output logic             bus_rvalid_o,
  // pins
  input  wire logic        event_input_pin_i,
  output logic             square_output_pin_o,
  output logic             timer_owns_pin_o,
  // interrupts
  output logic             chan0_match_irq_o,
  output logic             chan1_match_irq_o
);
  import tmr_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  tmr_state_t state_reg; // registered state
  tmr_state_t state_next; // next state
  logic       run0; // channel 0 enabled
  logic       run1; // channel 1 enabled
  logic       tick0; // selected count tick, channel 0
  logic       tick1; // selected count tick, channel 1
  logic       hit0; // match on this tick, channel 0
  logic       hit1; // match on this tick, channel 1
  logic [1:0] src1; // channel 1 source select

  tmr_tick_if tick_bus(); // divider ticks

  // ****************************************
  // prescaler
  // ****************************************
  tmr_prescaler u_pre (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tk      (tick_bus.src)
  );

  // ****************************************
  // helpers
  // ****************************************
  // counter step: hold zero stopped, wrap on match, else count
  function automatic logic [7:0] next_count(input logic run,
                                            input logic tick,
                                            input logic [7:0] cnt,
                                            input logic [7:0] cmp);
    if (!run) begin
      return CNT_RESET;
    end else if (tick && cnt == cmp) begin
      return CNT_RESET;
    end else if (tick) begin
      return 8'(cnt + 8'h01);
    end
    return cnt;
  endfunction

  // single-bit update of a control byte
  function automatic logic [7:0] put_bit(input logic [7:0] v,
                                         input logic [2:0] pos,
                                         input logic b);
    logic [7:0] r;
    r = v;
    r[pos] = b;
    return r;
  endfunction

  // ****************************************
  // tick selection and match
  // ****************************************
  always_comb begin
    run0 = state_reg.ctrl0[RUN_BIT];
    run1 = state_reg.ctrl1[RUN_BIT];
    src1 = {state_reg.ctrl1[SRC_HI], state_reg.ctrl1[SRC_LO]};
    // channel 0 clock choice
    if (state_reg.ctrl0[CLK0_BIT]) begin
      tick0 = tick_bus.tick512;
    end else begin
      tick0 = tick_bus.tick64;
    end
    // channel 1 source choice
    case (src1)
      SRC_DIV16: begin
        tick1 = tick_bus.tick16;
      end
      SRC_DIV256: begin
        tick1 = tick_bus.tick256;
      end
      SRC_RISE: begin
        tick1 = event_input_pin_i && !state_reg.ev_prev;
      end
      SRC_FALL: begin
        tick1 = !event_input_pin_i && state_reg.ev_prev;
      end
      default: begin
        tick1 = 1'b0;
      end
    endcase
    // compare equality on a count tick
    hit0 = run0 && tick0 && (state_reg.cnt0 == state_reg.cmp0);
    hit1 = run1 && tick1 && (state_reg.cnt1 == state_reg.cmp1);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.ev_prev = event_input_pin_i;
    // counters, cleared on match or stop
    state_next.cnt0 = next_count(run0, tick0, state_reg.cnt0,
                                 state_reg.cmp0);
    state_next.cnt1 = next_count(run1, tick1, state_reg.cnt1,
                                 state_reg.cmp1);
    // interrupt pulses on each match
    state_next.irq0 = hit0;
    state_next.irq1 = hit1;
    // square wave: toggle on match, zero while stopped
    if (!run1) begin
      state_next.sq = 1'b0;
    end else if (hit1) begin
      state_next.sq = !state_reg.sq;
    end
    // register writes, byte or single bit
    if (bus_wr_i && bus_bit_i) begin
      case (bus_addr_i)
        ADDR_CTRL0: begin
          state_next.ctrl0 = put_bit(state_reg.ctrl0, bus_bit_pos_i,
                             bus_wdata_i[bus_bit_pos_i]) & CTRL0_MASK;
        end
        ADDR_CTRL1: begin
          state_next.ctrl1 = put_bit(state_reg.ctrl1, bus_bit_pos_i,
                             bus_wdata_i[bus_bit_pos_i]) & CTRL1_MASK;
        end
        default: begin
          // bit writes elsewhere are ignored
        end
      endcase
    end else if (bus_wr_i) begin
      case (bus_addr_i)
        ADDR_CTRL0: begin
          state_next.ctrl0 = bus_wdata_i & CTRL0_MASK;
        end
        ADDR_CTRL1: begin
          state_next.ctrl1 = bus_wdata_i & CTRL1_MASK;
        end
        ADDR_CMP0: begin
          state_next.cmp0 = bus_wdata_i;
        end
        ADDR_CMP1: begin
          state_next.cmp1 = bus_wdata_i;
        end
        default: begin
          // counters are read only; others unmapped
        end
      endcase
    end
    // register reads, answered next cycle
    state_next.rvalid = bus_rd_i;
    if (bus_rd_i) begin
      case (bus_addr_i)
        ADDR_CNT0: begin
          state_next.rdata = state_reg.cnt0;
        end
        ADDR_CNT1: begin
          state_next.rdata = state_reg.cnt1;
        end
        ADDR_CMP0: begin
          state_next.rdata = state_reg.cmp0;
        end
        ADDR_CMP1: begin
          state_next.rdata = state_reg.cmp1;
        end
        ADDR_CTRL0: begin
          state_next.rdata = state_reg.ctrl0;
        end
        ADDR_CTRL1: begin
          state_next.rdata = state_reg.ctrl1;
        end
        default: begin
          state_next.rdata = RD_UNMAPPED;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '{CTRL_RESET, CTRL_RESET, CMP_RESET, CMP_RESET,
                     CNT_RESET, CNT_RESET, 1'b0, 1'b0, 1'b0, 1'b0,
                     RD_UNMAPPED, 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // outputs, all from flip-flops
  // ****************************************
  assign bus_rdata_o = state_reg.rdata;
  assign bus_rvalid_o = state_reg.rvalid;
  assign square_output_pin_o = state_reg.sq;
  assign timer_owns_pin_o = state_reg.ctrl1[OE_BIT];
  assign chan0_match_irq_o = state_reg.irq0;
  assign chan1_match_irq_o = state_reg.irq1;

  // ****************************************
  // checks
  // ****************************************
  property p_stop_clears0;
    @(posedge clk_i) disable iff (reset_i)
    !run0 |=> state_reg.cnt0 == CNT_RESET;
  endproperty
  a_stop_clears0: assert property (p_stop_clears0)
    else $error("channel 0 counter not cleared while stopped");

  property p_stop_clears1;
    @(posedge clk_i) disable iff (reset_i)
    !run1 |=> state_reg.cnt1 == CNT_RESET && !chan1_match_irq_o;
  endproperty
  a_stop_clears1: assert property (p_stop_clears1)
    else $error("channel 1 counter not cleared while stopped");

  property p_match_wrap0;
    @(posedge clk_i) disable iff (reset_i)
    hit0 |=> chan0_match_irq_o && state_reg.cnt0 == CNT_RESET;
  endproperty
  a_match_wrap0: assert property (p_match_wrap0)
    else $error("channel 0 match did not wrap and interrupt");

  property p_irq_cause1;
    @(posedge clk_i) disable iff (reset_i)
    chan1_match_irq_o |-> $past(hit1);
  endproperty
  a_irq_cause1: assert property (p_irq_cause1)
    else $error("channel 1 interrupt without match");

  property p_advance0;
    @(posedge clk_i) disable iff (reset_i)
    run0 && tick0 && !hit0 |=>
      state_reg.cnt0 == 8'($past(state_reg.cnt0) + 8'h01);
  endproperty
  a_advance0: assert property (p_advance0)
    else $error("channel 0 counter did not advance on tick");

  property p_hold1;
    @(posedge clk_i) disable iff (reset_i)
    run1 && !tick1 |=> $stable(state_reg.cnt1);
  endproperty
  a_hold1: assert property (p_hold1)
    else $error("channel 1 counter moved without a tick");

  property p_sq_toggle;
    @(posedge clk_i) disable iff (reset_i)
    hit1 |=> square_output_pin_o != $past(square_output_pin_o);
  endproperty
  a_sq_toggle: assert property (p_sq_toggle)
    else $error("square output did not toggle on match");

  property p_sq_stop;
    @(posedge clk_i) disable iff (reset_i)
    !run1 |=> !square_output_pin_o;
  endproperty
  a_sq_stop: assert property (p_sq_stop)
    else $error("square output not zero while stopped");

  property p_reserved0;
    @(posedge clk_i) disable iff (reset_i)
    bus_wr_i && !bus_bit_i && bus_addr_i == ADDR_CTRL0 |=>
      state_reg.ctrl0 == ($past(bus_wdata_i) & CTRL0_MASK);
  endproperty
  a_reserved0: assert property (p_reserved0)
    else $error("control 0 byte write not stored");

endmodule

// [tmr_pkg.sv]
// constants, register map and state types of the dual 8-bit timer
package tmr_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [15:0] ADDR_CNT0  = 16'hff50; // channel 0 count, read
  localparam logic [15:0] ADDR_CMP0  = 16'hff51; // channel 0 compare
  localparam logic [15:0] ADDR_CTRL0 = 16'hff53; // channel 0 mode control
  localparam logic [15:0] ADDR_CNT1  = 16'hff54; // channel 1 count, read
  localparam logic [15:0] ADDR_CMP1  = 16'hff55; // channel 1 compare
  localparam logic [15:0] ADDR_CTRL1 = 16'hff57; // channel 1 mode control

  // ****************************************
  // control field positions and masks
  // ****************************************
  localparam int RUN_BIT = 7; // run enable, both channels
  localparam int CLK0_BIT = 1; // channel 0 clock select
  localparam int SRC_LO = 1; // channel 1 source select low
  localparam int SRC_HI = 2; // channel 1 source select high
  localparam int OE_BIT = 0; // channel 1 output enable
  localparam logic [7:0] CTRL0_MASK = 8'h82; // implemented bits
  localparam logic [7:0] CTRL1_MASK = 8'h87; // implemented bits

  // ****************************************
  // reset and read values
  // ****************************************
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] CNT_RESET   = 8'h00;
  localparam logic [7:0] CMP_RESET   = 8'h00; // stands for undefined
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ****************************************
  // channel 1 count sources
  // ****************************************
  localparam logic [1:0] SRC_DIV16  = 2'b00;
  localparam logic [1:0] SRC_DIV256 = 2'b01;
  localparam logic [1:0] SRC_RISE   = 2'b10;
  localparam logic [1:0] SRC_FALL   = 2'b11;

  // ****************************************
  // prescaler
  // ****************************************
  localparam logic [8:0] PRE_RESET  = 9'h000;
  localparam logic [8:0] DIV16_MASK = 9'h00f;
  localparam logic [8:0] DIV64_MASK = 9'h03f;
  localparam logic [8:0] DIV256_MASK = 9'h0ff;
  localparam logic [8:0] DIV512_MASK = 9'h1ff;

  typedef struct packed {
    logic [8:0] cnt; // free-running divider
    logic       t16; // one-cycle tick pulses
    logic       t64;
    logic       t256;
    logic       t512;
  } tmr_pre_state_t;

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] cmp0;
    logic [7:0] cmp1;
    logic [7:0] cnt0;
    logic [7:0] cnt1;
    logic       irq0;
    logic       irq1;
    logic       sq; // square wave level
    logic       ev_prev; // event pin, last cycle
    logic [7:0] rdata;
    logic       rvalid;
  } tmr_state_t;

endpackage

// [tmr_tick_if.sv]
// prescaler tick pulses passed from divider to timer core
`timescale 1ns/1ns
interface tmr_tick_if;
  logic tick16;  // clk / 16
  logic tick64;  // clk / 64
  logic tick256; // clk / 256
  logic tick512; // clk / 512
  modport src (output tick16, output tick64, output tick256, output tick512);
  modport dst (input tick16, input tick64, input tick256, input tick512);
endinterface

// [tmr_prescaler.sv]
// system clock divider producing the timer count ticks
`timescale 1ns/1ns
module tmr_prescaler (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // tick outputs
  tmr_tick_if.src   tk
);
  import tmr_pkg::*;

  tmr_pre_state_t state_reg; // registered state
  tmr_pre_state_t state_next; // next state

  // true when all masked low bits are ones
  function automatic logic full(input logic [8:0] c, input logic [8:0] m);
    return (c & m) == m;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.cnt = 9'(state_reg.cnt + 9'h001);
    state_next.t16 = full(state_reg.cnt, DIV16_MASK);
    state_next.t64 = full(state_reg.cnt, DIV64_MASK);
    state_next.t256 = full(state_reg.cnt, DIV256_MASK);
    state_next.t512 = full(state_reg.cnt, DIV512_MASK);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '{PRE_RESET, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign tk.tick16 = state_reg.t16;
  assign tk.tick64 = state_reg.t64;
  assign tk.tick256 = state_reg.t256;
  assign tk.tick512 = state_reg.t512;

  // ****************************************
  // checks
  // ****************************************
  property p_tick16_period;
    @(posedge clk_i) disable iff (reset_i)
    state_reg.t16 |=>
      !state_reg.t16 [*8] ##1 !state_reg.t16 [*7] ##1 state_reg.t16;
  endproperty
  a_tick16_period: assert property (p_tick16_period)
    else $error("divide-by-16 tick period wrong");

  property p_tick64_period;
    @(posedge clk_i) disable iff (reset_i)
    state_reg.t64 |-> ##64 state_reg.t64;
  endproperty
  a_tick64_period: assert property (p_tick64_period)
    else $error("divide-by-64 tick period wrong");

endmodule

// [tmr_pulse_src.sv]
// behavioural pulse source standing on the external event pin
`timescale 1ns/1ns
module tmr_pulse_src #(
  parameter int HALF = 4 // cycles per pulse half
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // control from the bench
  input  wire logic       start_i,
  input  wire logic [7:0] count_i,
  input  wire logic       owns_pin_i,
  // pin side
  output logic            pin_o,
  output logic            done_o
);
  // ****************************************
  // pulse train
  // ****************************************
  // idle low between trains
  initial begin
    pin_o = 1'b0;
    done_o = 1'b0;
  end

  // start seen at a rising edge, pin moved on falling edges
  always begin
    @(posedge clk_i);
    // pin stays quiet while the timer drives it
    if (start_i && !reset_i && !owns_pin_i) begin
      // non-blocking so the bench sees done for one whole cycle
      for (int i = 0; i < count_i; i++) begin
        repeat (HALF) @(negedge clk_i);
        pin_o <= 1'b1;
        repeat (HALF) @(negedge clk_i);
        pin_o <= 1'b0;
      end
      repeat (HALF) @(negedge clk_i);
      done_o <= 1'b1;
      @(negedge clk_i);
      done_o <= 1'b0;
    end
  end
endmodule

// [testbench.sv]
// self-checking bench of the dual 8-bit timer
`timescale 1ns/1ns
module testbench;
  import tmr_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic        clk_i;
  logic        reset_i;
  logic [15:0] addr;
  logic        wr;
  logic        bit_wr;
  logic [2:0]  bit_pos;
  logic [7:0]  wdata;
  logic        rd;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        ev_pin;
  logic        sq_pin;
  logic        owns;
  logic        irq0;
  logic        irq1;
  logic        pstart;
  logic [7:0]  pcount;
  logic        pdone;
  logic [15:0] n_irq1;  // channel 1 matches seen
  logic [15:0] per;     // expected match period
  logic [15:0] w;       // cycles waited
  logic [15:0] ca;      // control address
  logic [15:0] ma;      // compare address
  logic [15:0] na;      // count address
  logic        sq_a;    // square level at first match
  logic [1:0]  src;     // event source
  int          n_mismatch;
  int          n_compared;
  int          cyc;

  // one row: channel, control, compare, count divider
  typedef struct packed {
    logic        ch;
    logic [7:0]  ctrl;
    logic [7:0]  cmp;
    logic [15:0] div;
  } tmr_row_t;
  localparam tmr_row_t ROWS [6] = '{
    '{1'b0, 8'h80, 8'h02, 16'h0040}, '{1'b0, 8'h82, 8'h01, 16'h0200},
    '{1'b1, 8'h80, 8'h03, 16'h0010}, '{1'b1, 8'h82, 8'h00, 16'h0100},
    '{1'b1, 8'h81, 8'h04, 16'h0010}, '{1'b1, 8'h80, 8'hff, 16'h0010}};

  // ****************************************
  // design and partner
  // ****************************************
  tmr_dual_timer u_dut (
    .clk_i               (clk_i),
    .reset_i             (reset_i),
    .bus_addr_i          (addr),
    .bus_wr_i            (wr),
    .bus_bit_i           (bit_wr),
    .bus_bit_pos_i       (bit_pos),
    .bus_wdata_i         (wdata),
    .bus_rd_i            (rd),
    .bus_rdata_o         (rdata),
    .bus_rvalid_o        (rvalid),
    .event_input_pin_i   (ev_pin),
    .square_output_pin_o (sq_pin),
    .timer_owns_pin_o    (owns),
    .chan0_match_irq_o   (irq0),
    .chan1_match_irq_o   (irq1)
  );
  tmr_pulse_src u_src (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .start_i    (pstart),
    .count_i    (pcount),
    .owns_pin_i (owns),
    .pin_o      (ev_pin),
    .done_o     (pdone)
  );

  // ****************************************
  // clock, timeout, match counter
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // cuts a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      final_report();
    end
  end

  // counts channel 1 interrupt pulses
  always @(posedge clk_i) begin
    if (irq1 === 1'b1) begin
      n_irq1 <= n_irq1 + 16'h0001;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write, taken at the rising edge in between
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d,
                        input logic b, input logic [2:0] p);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    bit_wr = b;
    bit_pos = p;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask

  // one read, answer a cycle later
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp,
                        input string what);
    @(negedge clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_i);
    rd = 1'b0;
    check("read valid", 16'h0001, {15'h0000, rvalid});
    check(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  // bounded wait for a channel interrupt pulse
  task automatic wait_irq(input logic ch, input logic [15:0] max,
                          output logic [15:0] n);
    n = 16'h0000;
    do begin
      @(negedge clk_i);
      n = n + 16'h0001;
    end while ((ch ? irq1 : irq0) !== 1'b1 && n < max);
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_i = 1'b1;
    addr = 16'h0000;
    wr = 1'b0;
    bit_wr = 1'b0;
    bit_pos = 3'h0;
    wdata = 8'h00;
    rd = 1'b0;
    pstart = 1'b0;
    pcount = 8'h00;
    n_irq1 = 16'h0000;
    n_mismatch = 0;
    n_compared = 0;
    cyc = 0;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    // interval rows: stop, program, then run
    foreach (ROWS[i]) begin
      ca = ROWS[i].ch ? ADDR_CTRL1 : ADDR_CTRL0;
      ma = ROWS[i].ch ? ADDR_CMP1 : ADDR_CMP0;
      na = ROWS[i].ch ? ADDR_CNT1 : ADDR_CNT0;
      per = 16'((int'(ROWS[i].cmp) + 1) * int'(ROWS[i].div));
      bus_wr(ca, 8'h00, 1'b0, 3'h0);
      bus_wr(ma, ROWS[i].cmp, 1'b0, 3'h0);
      bus_wr(ca, ROWS[i].ctrl & 8'h7f, 1'b0, 3'h0);
      bus_wr(ca, ROWS[i].ctrl, 1'b0, 3'h0);
      wait_irq(ROWS[i].ch, per + 16'h0008, w);
      sq_a = sq_pin;
      wait_irq(ROWS[i].ch, per + 16'h0008, w);
      check("match period", per, w);
      rd_chk(na, CNT_RESET, "count after match");
      // square output and pin owner only with output enable set
      if (ROWS[i].ctrl[OE_BIT]) begin
        check("square toggle", {15'h0, !sq_a}, {15'h0, sq_pin});
        check("pin owner", 16'h0001, {15'h0000, owns});
      end
      bus_wr(ca, 8'h00, 1'b0, 3'h0);
      rd_chk(na, CNT_RESET, "count stopped");
      check("square stopped", 16'h0000, {15'h0000, sq_pin});
    end
    // control masks and single-bit writes
    bus_wr(ADDR_CTRL0, 8'hff, 1'b0, 3'h0);
    rd_chk(ADDR_CTRL0, CTRL0_MASK, "ctrl0 mask");
    bus_wr(ADDR_CTRL0, 8'h00, 1'b0, 3'h0);
    bus_wr(ADDR_CTRL0, 8'h02, 1'b1, 3'h1);
    bus_wr(ADDR_CTRL0, 8'h40, 1'b1, 3'h6);
    rd_chk(ADDR_CTRL0, 8'h02, "ctrl0 bit writes");
    bus_wr(ADDR_CTRL0, 8'h00, 1'b0, 3'h0);
    rd_chk(ADDR_CMP0, 8'h01, "compare0 held");
    bus_wr(ADDR_CTRL1, 8'h79, 1'b0, 3'h0);
    rd_chk(ADDR_CTRL1, 8'h01, "ctrl1 byte");
    bus_wr(ADDR_CTRL1, 8'h80, 1'b1, 3'h7);
    rd_chk(ADDR_CTRL1, 8'h81, "ctrl1 bit set");
    bus_wr(ADDR_CTRL1, 8'h7f, 1'b1, 3'h7);
    rd_chk(ADDR_CTRL1, 8'h01, "ctrl1 bit clear");
    bus_wr(ADDR_CTRL1, 8'h00, 1'b0, 3'h0);
    bus_wr(ADDR_CNT1, 8'h55, 1'b0, 3'h0);
    rd_chk(ADDR_CNT1, CNT_RESET, "count write ignored");
    rd_chk(ADDR_CMP1, 8'hff, "compare kept");
    rd_chk(16'hff52, RD_UNMAPPED, "unmapped read");
    // event counting, both edges, compare 3 over six edges
    for (int k = 0; k < 2; k++) begin
      src = (k == 0) ? SRC_RISE : SRC_FALL;
      bus_wr(ADDR_CTRL1, 8'h00, 1'b0, 3'h0);
      bus_wr(ADDR_CMP1, 8'h03, 1'b0, 3'h0);
      bus_wr(ADDR_CTRL1, {5'h00, src, 1'b0}, 1'b0, 3'h0);
      bus_wr(ADDR_CTRL1, {5'h10, src, 1'b0}, 1'b0, 3'h0);
      @(negedge clk_i);
      n_irq1 = 16'h0000;
      pcount = 8'h06;
      pstart = 1'b1;
      @(negedge clk_i);
      pstart = 1'b0;
      w = 16'h0000;
      while (pdone !== 1'b1 && w < 16'h0100) begin
        @(negedge clk_i);
        w = w + 16'h0001;
      end
      rd_chk(ADDR_CNT1, 8'h02, "event count");
      check("event matches", 16'h0001, n_irq1);
    end
    // second reset while channel 0 runs
    bus_wr(ADDR_CTRL0, 8'h80, 1'b0, 3'h0);
    repeat (100) @(negedge clk_i);
    reset_i = 1'b1;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    rd_chk(ADDR_CTRL0, CTRL_RESET, "ctrl0 after reset");
    rd_chk(ADDR_CTRL1, CTRL_RESET, "ctrl1 after reset");
    rd_chk(ADDR_CNT0, CNT_RESET, "count0 after reset");
    rd_chk(ADDR_CNT1, CNT_RESET, "count1 after reset");
    check("owner after reset", 16'h0000, {15'h0000, owns});
    final_report();
  end
endmodule
